// >>> inc/cks_pkg.sv
// Purpose: Constants and types for the system clock source selector.
// Assumes: 25 MHz system clock; Wishbone classic register access.
// Notes: Oscillator sources enter as single-cycle ticks.
`default_nettype none
package cks_pkg;
  // System clock rate.
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  // Fail-safe monitor: longest silence of the running source.
  localparam int unsigned FAIL_SAFE_CLOCK_MONITOR_TIME_NS = 2000;
  localparam logic [7:0] FAIL_SAFE_CLOCK_MONITOR_CYC = 8'(FAIL_SAFE_CLOCK_MONITOR_TIME_NS / CLK_NS);
  // Register offsets (byte addresses).
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  // Control register fields.
  localparam int unsigned CTRL_SRC_LSB = 0;
  localparam int unsigned CTRL_REQ_BIT = 4;
  // Status register fields.
  localparam int unsigned STAT_SRC_LSB = 0;
  localparam int unsigned STAT_SWEN_BIT = 4;
  localparam int unsigned STAT_FAIL_SAFE_CLOCK_MONITOR_BIT = 5;
  localparam int unsigned STAT_FAIL_BIT = 6;
  localparam int unsigned STAT_BUSY_BIT = 7;
  // Configuration word 2 field positions.
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_OUTFN_BIT = 5;
  localparam int unsigned CFG_SWMON_LSB = 6;
  localparam int unsigned CFG_ISRC_LSB = 8;
  // Erased configuration values.
  localparam logic [2:0] RST_ISRC = 3'h7;
  localparam logic [1:0] RST_MODE = 2'h3;
  localparam logic [1:0] RST_SWMON = 2'h3;
  localparam logic RST_OUTFN = 1'h1;
  localparam logic [2:0] RST_DIV = 3'h0;
  // Initial source codes.
  localparam logic [2:0] ISRC_FAST_RC = 3'h0;
  localparam logic [2:0] ISRC_FAST_RC_MUL = 3'h1;
  localparam logic [2:0] ISRC_PRIMARY = 3'h2;
  localparam logic [2:0] ISRC_PRIMARY_MUL = 3'h3;
  localparam logic [2:0] ISRC_SECONDARY = 3'h4;
  localparam logic [2:0] ISRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] ISRC_RESERVED = 3'h6;
  localparam logic [2:0] ISRC_FAST_RC_DIV = 3'h7;
  // Primary mode codes.
  localparam logic [1:0] MODE_EXT_CLOCK = 2'h0;
  localparam logic [1:0] MODE_CRYSTAL = 2'h1;
  localparam logic [1:0] MODE_HS_CRYSTAL = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  // Multiplier extra ticks after each source tick.
  localparam logic [1:0] MUL_EXTRA = 2'h3;
  // Physical oscillator behind a selection.
  typedef enum logic [1:0] {
    OSC_PRIMARY = 2'h0,
    OSC_SECONDARY = 2'h1,
    OSC_FAST_RC = 2'h2,
    OSC_LOW_POWER_RC = 2'h3
  } cks_osc_t;
  // Controller states.
  typedef enum logic [2:0] {
    ST_BOOT = 3'h1,
    ST_RUN = 3'h2,
    ST_SWITCH = 3'h4
  } cks_st_t;
  // Decoded source selection.
  typedef struct packed {
    cks_osc_t osc;
    logic mul;
    logic div;
  } cks_sel_t;
  // Oscillator ticks.
  typedef struct packed {
    logic primary_osc;
    logic secondary_osc;
    logic fast_internal_rc;
    logic low_power_internal_rc;
  } cks_osc_ticks_t;
  // Wishbone request from the master.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cks_wb_req_t;
  // Whole state of the selector.
  typedef struct packed {
    cks_st_t st;
    logic [2:0] src;
    logic [1:0] mode;
    logic [1:0] swmon;
    logic outfn;
    logic [2:0] nsrc;
    logic [2:0] div;
    logic [1:0] mul;
    logic [7:0] dcnt;
    logic [7:0] wcnt;
    logic fail;
    logic ptick;
    logic itick;
    logic itog;
    logic ack;
    logic [31:0] dat;
  } cks_state_t;
endpackage
`default_nettype wire

// >>> rtl/cks_select.sv
// Purpose: System clock source selector with multiplier, divider and fail-safe monitor.
// Assumes: Oscillator ticks are synchronous single-cycle pulses at least four cycles apart when multiplied.
// Notes: Clock outputs are tick strobes and levels in the 25 MHz domain.
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Clock comes from exactly one of four oscillators.
// - Times-four multiplier only for primary or fast RC.
// - Programmable divider slows the fast RC clock.
// - Instruction clock is processor clock halved.
// - Instruction clock may drive the primary output pin.
// - Reset source from mode bits 1:0, source 10:8.
// - Erased device starts on divided fast RC.
// - Switching allowed only when upper field bit zero.
// - Fail-safe monitor only when both field bits zero.
// - Primary code 011 multiplies, 010 bypasses; modes 00/01/10.
// - Code 001 selects fast RC times four.
// - Code 000 selects plain fast RC, primary off.
// - Code 101 low-power RC; 110 reserved.
// - Code 100 selects the secondary oscillator.
// - Separate bit makes output pin clock or I/O.
module cks_select (
  // Clock, reset and enable.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Nonvolatile configuration word 2.
  input wire logic [15:0] cfg_word2_i,
  // Oscillator ticks.
  input wire cks_pkg::cks_osc_ticks_t osc_tick_i,
  // Wishbone slave.
  input wire cks_pkg::cks_wb_req_t wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Clock outputs.
  output logic processor_clock_tick_o,
  output logic instruction_cycle_clock_tick_o,
  output logic instruction_cycle_clock_o,
  output logic primary_osc_en_o,
  output logic primary_osc_out_pin_o,
  output logic primary_osc_out_pin_oe_o
);

  cks_pkg::cks_state_t s_q;
  cks_pkg::cks_state_t s_d;
  cks_pkg::cks_sel_t sel;
  cks_pkg::cks_sel_t nsel;
  logic raw;
  logic nraw;
  logic wr;
  logic sw_en;
  logic fail_safe_clock_monitor_en;
  logic [7:0] dlim;

  // Decodes a source code and primary mode to an oscillator path.
  function automatic cks_pkg::cks_sel_t decode(input logic [2:0] code, input logic [1:0] mode);
    cks_pkg::cks_sel_t r;
    r.osc = cks_pkg::OSC_FAST_RC;
    r.mul = 1'b0;
    r.div = 1'b0;
    case (code)
      cks_pkg::ISRC_FAST_RC_MUL: begin
        r.mul = 1'b1;
      end
      cks_pkg::ISRC_PRIMARY, cks_pkg::ISRC_PRIMARY_MUL: begin
        // A primary selection with the primary disabled falls back to fast RC.
        if (mode != cks_pkg::MODE_OFF) begin
          r.osc = cks_pkg::OSC_PRIMARY;
          r.mul = (code == cks_pkg::ISRC_PRIMARY_MUL);
        end
      end
      cks_pkg::ISRC_SECONDARY: begin
        r.osc = cks_pkg::OSC_SECONDARY;
      end
      cks_pkg::ISRC_LOW_POWER_RC: begin
        r.osc = cks_pkg::OSC_LOW_POWER_RC;
      end
      cks_pkg::ISRC_FAST_RC_DIV, cks_pkg::ISRC_RESERVED: begin
        r.div = 1'b1;
      end
      default: begin
        r.osc = cks_pkg::OSC_FAST_RC;
      end
    endcase
    return r;
  endfunction

  // Picks the tick of one oscillator.
  function automatic logic pick(input cks_pkg::cks_osc_t osc, input cks_pkg::cks_osc_ticks_t t);
    logic r;
    r = 1'b0;
    case (osc)
      cks_pkg::OSC_PRIMARY: r = t.primary_osc;
      cks_pkg::OSC_SECONDARY: r = t.secondary_osc;
      cks_pkg::OSC_FAST_RC: r = t.fast_internal_rc;
      cks_pkg::OSC_LOW_POWER_RC: r = t.low_power_internal_rc;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Current and pending selections and the configuration gates.
  assign sel = decode(s_q.src, s_q.mode);
  assign nsel = decode(s_q.nsrc, s_q.mode);
  assign raw = pick(sel.osc, osc_tick_i);
  assign nraw = pick(nsel.osc, osc_tick_i);
  assign sw_en = (s_q.swmon[1] == 1'b0);
  assign fail_safe_clock_monitor_en = (s_q.swmon == 2'h0);
  assign dlim = 8'((9'h001 << s_q.div) - 9'h001);
  assign wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~s_q.ack & wb_req_i.sel[0];

  // Next-state logic for the whole selector.
  always_comb begin
    s_d = s_q;
    if (ce_i) begin
      // Bus answer one cycle after the request, dropped the cycle after.
      s_d.ack = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
      s_d.dat = 32'h0000_0000;
      if (wb_req_i.cyc & wb_req_i.stb & ~wb_req_i.we & ~s_q.ack) begin
        case (wb_req_i.adr)
          cks_pkg::REG_CTRL: s_d.dat[cks_pkg::CTRL_SRC_LSB +: 3] = s_q.nsrc;
          cks_pkg::REG_DIV: s_d.dat[2:0] = s_q.div;
          cks_pkg::REG_STAT: begin
            s_d.dat[cks_pkg::STAT_SRC_LSB +: 3] = s_q.src;
            s_d.dat[cks_pkg::STAT_SWEN_BIT] = sw_en;
            s_d.dat[cks_pkg::STAT_FAIL_SAFE_CLOCK_MONITOR_BIT] = fail_safe_clock_monitor_en;
            s_d.dat[cks_pkg::STAT_FAIL_BIT] = s_q.fail;
            s_d.dat[cks_pkg::STAT_BUSY_BIT] = (s_q.st == cks_pkg::ST_SWITCH);
          end
          cks_pkg::REG_CFG: begin
            s_d.dat[cks_pkg::CFG_MODE_LSB +: 2] = s_q.mode;
            s_d.dat[cks_pkg::CFG_OUTFN_BIT] = s_q.outfn;
            s_d.dat[cks_pkg::CFG_SWMON_LSB +: 2] = s_q.swmon;
          end
          default: s_d.dat = 32'h0000_0000;
        endcase
      end
      if (wr && wb_req_i.adr == cks_pkg::REG_DIV) begin
        s_d.div = wb_req_i.dat[2:0];
      end
      // Fail flag clears on a write of one; a new failure below wins.
      if (wr && wb_req_i.adr == cks_pkg::REG_STAT && wb_req_i.dat[cks_pkg::STAT_FAIL_BIT]) begin
        s_d.fail = 1'b0;
      end
      // Processor tick: direct, multiplied or divided.
      s_d.ptick = 1'b0;
      if (s_q.st != cks_pkg::ST_BOOT) begin
        if (sel.mul) begin
          if (raw) begin
            s_d.ptick = 1'b1;
            s_d.mul = cks_pkg::MUL_EXTRA;
          end else if (s_q.mul != 2'h0) begin
            s_d.ptick = 1'b1;
            s_d.mul = s_q.mul - 2'h1;
          end
        end else if (sel.div) begin
          if (raw) begin
            if (s_q.dcnt >= dlim) begin
              s_d.dcnt = 8'h00;
              s_d.ptick = 1'b1;
            end else begin
              s_d.dcnt = s_q.dcnt + 8'h01;
            end
          end
        end else begin
          s_d.ptick = raw;
        end
      end
      // Instruction clock toggles on every processor tick.
      s_d.itick = s_q.ptick & s_q.itog;
      if (s_q.ptick) begin
        s_d.itog = ~s_q.itog;
      end
      // Silence counter of the running source.
      if (raw) begin
        s_d.wcnt = 8'h00;
      end else if (s_q.wcnt != cks_pkg::FAIL_SAFE_CLOCK_MONITOR_CYC) begin
        s_d.wcnt = s_q.wcnt + 8'h01;
      end
      case (s_q.st)
        cks_pkg::ST_BOOT: begin
          // Configuration is caught once after reset release.
          s_d.src = cfg_word2_i[cks_pkg::CFG_ISRC_LSB +: 3];
          s_d.mode = cfg_word2_i[cks_pkg::CFG_MODE_LSB +: 2];
          s_d.swmon = cfg_word2_i[cks_pkg::CFG_SWMON_LSB +: 2];
          s_d.outfn = cfg_word2_i[cks_pkg::CFG_OUTFN_BIT];
          s_d.nsrc = cfg_word2_i[cks_pkg::CFG_ISRC_LSB +: 3];
          s_d.wcnt = 8'h00;
          s_d.st = cks_pkg::ST_RUN;
        end
        cks_pkg::ST_RUN: begin
          if (wr && wb_req_i.adr == cks_pkg::REG_CTRL) begin
            s_d.nsrc = wb_req_i.dat[cks_pkg::CTRL_SRC_LSB +: 3];
            if (wb_req_i.dat[cks_pkg::CTRL_REQ_BIT] && sw_en) begin
              s_d.st = cks_pkg::ST_SWITCH;
            end
          end
        end
        cks_pkg::ST_SWITCH: begin
          // Old source runs until the new one proves alive.
          if (nraw) begin
            s_d.src = s_q.nsrc;
            s_d.mul = 2'h0;
            s_d.dcnt = 8'h00;
            s_d.wcnt = 8'h00;
            s_d.st = cks_pkg::ST_RUN;
          end
        end
        default: begin
          s_d.st = cks_pkg::ST_RUN;
        end
      endcase
      // Fail-safe: a silent source gives way to the fast RC.
      if (fail_safe_clock_monitor_en && s_q.st != cks_pkg::ST_BOOT && s_q.wcnt == cks_pkg::FAIL_SAFE_CLOCK_MONITOR_CYC
          && s_q.src != cks_pkg::ISRC_FAST_RC) begin
        s_d.src = cks_pkg::ISRC_FAST_RC;
        s_d.nsrc = cks_pkg::ISRC_FAST_RC;
        s_d.fail = 1'b1;
        s_d.mul = 2'h0;
        s_d.wcnt = 8'h00;
        s_d.st = cks_pkg::ST_RUN;
      end
    end
  end

  // State register with erased-device defaults.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.st <= cks_pkg::ST_BOOT;
      s_q.src <= cks_pkg::RST_ISRC;
      s_q.mode <= cks_pkg::RST_MODE;
      s_q.swmon <= cks_pkg::RST_SWMON;
      s_q.outfn <= cks_pkg::RST_OUTFN;
      s_q.nsrc <= cks_pkg::RST_ISRC;
      s_q.div <= cks_pkg::RST_DIV;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs from the state register, the primary enable decoded from it.
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign processor_clock_tick_o = s_q.ptick;
  assign instruction_cycle_clock_tick_o = s_q.itick;
  assign instruction_cycle_clock_o = s_q.itog;
  assign primary_osc_en_o = (sel.osc == cks_pkg::OSC_PRIMARY);
  assign primary_osc_out_pin_o = s_q.itog;
  // Pin drives the clock only in external clock or primary-off modes.
  assign primary_osc_out_pin_oe_o = s_q.outfn & s_q.st != cks_pkg::ST_BOOT
    & (s_q.mode == cks_pkg::MODE_EXT_CLOCK | s_q.mode == cks_pkg::MODE_OFF);

  // Checks on the selector.
  AST_MUL_BURST: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && raw && sel.mul && s_q.st != cks_pkg::ST_BOOT) |=> processor_clock_tick_o[*4])
    else $error("Multiplier did not give four ticks.");
  AST_MUL_SOURCES: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    sel.mul |-> (sel.osc == cks_pkg::OSC_PRIMARY || sel.osc == cks_pkg::OSC_FAST_RC))
    else $error("Multiplier on wrong source.");
  AST_DIV_FRC: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    sel.div |-> (sel.osc == cks_pkg::OSC_FAST_RC && !sel.mul))
    else $error("Divider outside fast RC path.");
  AST_INSTR_HALF: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && processor_clock_tick_o) |=> (instruction_cycle_clock_o != $past(instruction_cycle_clock_o)))
    else $error("Instruction clock missed a processor tick.");
  AST_PIN_GATE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    primary_osc_out_pin_oe_o |-> (s_q.outfn && s_q.mode != cks_pkg::MODE_CRYSTAL))
    else $error("Output pin driven without its function bit.");
  AST_BOOT_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && s_q.st == cks_pkg::ST_BOOT) |=> (s_q.src == $past(cfg_word2_i[10:8])
    && s_q.mode == $past(cfg_word2_i[1:0]) && s_q.st == cks_pkg::ST_RUN))
    else $error("Configuration not captured at boot.");
  AST_ERASED_DEFAULT: assert property (@(posedge sys_clk_i)
    (!sys_rst_i && $past(sys_rst_i)) |-> (s_q.src == 3'h7 && s_q.mode == 2'h3 && sel.div))
    else $error("Reset source is not divided fast RC.");
  AST_SWITCH_LOCK: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.st == cks_pkg::ST_RUN && s_q.swmon[1]) |=> s_q.st != cks_pkg::ST_SWITCH)
    else $error("Switch started while locked.");
  AST_FAIL_SAFE_CLOCK_MONITOR_GATE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(s_q.fail) |-> ($past(s_q.swmon) == 2'h0 && s_q.src == 3'h0 && $past(s_q.wcnt) == 8'd50))
    else $error("Fail-safe acted while disabled.");
  AST_PRIMARY_OFF: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.src == 3'h0 || s_q.src[2]) |-> !primary_osc_en_o)
    else $error("Primary enabled for internal source.");

  // Direct path passes each source tick after one cycle.
  AST_DIRECT_TICK: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && raw && !sel.mul && !sel.div && s_q.st != cks_pkg::ST_BOOT)
    |=> processor_clock_tick_o)
    else $error("Direct path lost a source tick.");
  // No processor tick leaves while the configuration is being caught.
  AST_BOOT_QUIET: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && s_q.st == cks_pkg::ST_BOOT)
    |=> !processor_clock_tick_o)
    else $error("Processor tick during boot.");
  // Every second processor tick gives an instruction tick.
  AST_INSTR_TICK: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && processor_clock_tick_o && instruction_cycle_clock_o)
    |=> instruction_cycle_clock_tick_o)
    else $error("Instruction tick missing.");
  // No instruction tick without a processor tick before it.
  AST_INSTR_ONLY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && !processor_clock_tick_o)
    |=> !instruction_cycle_clock_tick_o)
    else $error("Instruction tick without processor tick.");
  // The pin carries the clock only in the modes that free it.
  AST_PIN_MODE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    primary_osc_out_pin_oe_o
    |-> (s_q.mode == cks_pkg::MODE_EXT_CLOCK || s_q.mode == cks_pkg::MODE_OFF))
    else $error("Output pin driven in a crystal mode.");
  // A disabled monitor never raises the fail flag.
  AST_FAIL_SAFE_CLOCK_MONITOR_OFF: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (ce_i && s_q.swmon != 2'h0 && !s_q.fail)
    |=> !s_q.fail)
    else $error("Fail flag set with monitor disabled.");
  // Primary with multiplier runs the primary through the multiplier.
  AST_PRIMARY_MUL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.src == cks_pkg::ISRC_PRIMARY_MUL && s_q.mode != cks_pkg::MODE_OFF)
    |-> (sel.mul && primary_osc_en_o))
    else $error("Primary multiplied code not honoured.");
  // Primary without multiplier bypasses it.
  AST_PRIMARY_BYPASS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.src == cks_pkg::ISRC_PRIMARY && s_q.mode != cks_pkg::MODE_OFF)
    |-> (!sel.mul && primary_osc_en_o))
    else $error("Primary bypass code not honoured.");
  // Fast RC with multiplier.
  AST_FAST_MUL: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.src == cks_pkg::ISRC_FAST_RC_MUL)
    |-> (sel.mul && sel.osc == cks_pkg::OSC_FAST_RC))
    else $error("Fast RC multiplied code not honoured.");
  // Plain fast RC has neither multiplier nor divider.
  AST_FAST_PLAIN: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.src == cks_pkg::ISRC_FAST_RC)
    |-> (sel.osc == cks_pkg::OSC_FAST_RC && !sel.mul && !sel.div))
    else $error("Plain fast RC code not honoured.");
  // Low-power RC runs without the multiplier.
  AST_LOW_POWER: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.src == cks_pkg::ISRC_LOW_POWER_RC)
    |-> (sel.osc == cks_pkg::OSC_LOW_POWER_RC && !sel.mul))
    else $error("Low-power RC code not honoured.");
  // Secondary oscillator runs plain.
  AST_SECONDARY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (s_q.src == cks_pkg::ISRC_SECONDARY)
    |-> (sel.osc == cks_pkg::OSC_SECONDARY && !sel.mul && !sel.div))
    else $error("Secondary code not honoured.");
  // A low clock enable freezes the whole state.
  AST_CE_FREEZE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (!ce_i)
    |=> $stable(s_q))
    else $error("State moved with clock enable low.");

endmodule
`default_nettype wire

// >>> verif/cks_osc_model.sv
// Purpose: Behavioural oscillators that feed one tick stream per source to the clock selector.
// Assumes: Each oscillator ticks once every PER cycles of the system clock.
// Notes: A stopped oscillator gives no ticks at all, like a dead crystal.
`timescale 1ns/1ns
`default_nettype none
module cks_osc_model #(
  parameter int PER_P = 8,
  parameter int PER_S = 12,
  parameter int PER_F = 10,
  parameter int PER_L = 14
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // Stop mask, one bit per oscillator in tick order.
  input wire logic [3:0] stop_i,
  // Oscillator ticks.
  output cks_pkg::cks_osc_ticks_t tick_o
);
  localparam int PER [4] = '{PER_L, PER_F, PER_S, PER_P};
  int cnt [4];
  logic [3:0] t;
  // Each oscillator counts out its own period; distinct periods tell sources apart.
  always @(posedge sys_clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (sys_rst_i || cnt[k] >= PER[k] - 1) cnt[k] <= 0;
      else cnt[k] <= cnt[k] + 1;
    end
  end
  // A tick stands one cycle at the wrap of its counter unless stopped.
  always_comb begin
    for (int k = 0; k < 4; k++) t[k] = !sys_rst_i && !stop_i[k] && (cnt[k] == 0);
  end
  assign tick_o = t;
endmodule
`default_nettype wire

// >>> verif/test_system_clock_source_select.sv
// Purpose: Self-checking bench for the clock source selector.
// Assumes: Wishbone answers one cycle after a request is seen; fail-safe silence is 50 cycles.
// Notes: Tick counts are compared with a small tolerance for window edges.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
  $display("MISMATCH %s exp %0h got %0h", nm, e, a); n_fail++; end end
module test_system_clock_source_select;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce = 1'b1;
  logic [15:0] cfg = 16'h0000;
  logic [3:0] stop = 4'h0;
  cks_pkg::cks_wb_req_t req = '0;
  cks_pkg::cks_osc_ticks_t tk;
  logic ack, pt, it, ic, pen, pin, poe;
  logic [31:0] rdat, q;
  int n_fail = 0;
  int n_checks = 0;
  int pc, icn, k, f;
  int st [4];
  logic meas = 1'b0;
  logic [1:0] w;
  logic o;
  logic [2:0] cs [11] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h0};
  logic [1:0] cm [11] = '{2'h3, 2'h0, 2'h3, 2'h3, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3};
  cks_select cks_select_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .cfg_word2_i(cfg),
    .osc_tick_i(tk), .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(rdat), .processor_clock_tick_o(pt),
    .instruction_cycle_clock_tick_o(it), .instruction_cycle_clock_o(ic), .primary_osc_en_o(pen),
    .primary_osc_out_pin_o(pin), .primary_osc_out_pin_oe_o(poe));
  cks_osc_model cks_osc_model_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .stop_i(stop), .tick_o(tk));
  // The clock toggles every 20 ns, half of its 40 ns period.
  initial forever #20 sys_clk_i = ~sys_clk_i;
  // Tick counters run only inside a measuring window.
  always @(posedge sys_clk_i) begin
    if (meas) begin
      pc += pt;
      icn += it;
      for (int j = 0; j < 4; j++) st[j] += tk[j];
    end
  end
  // Oscillator that stands behind an initial source code.
  function automatic int xk(input logic [2:0] s);
    case (s)
      3'h2, 3'h3: return 3;
      3'h4: return 2;
      3'h5: return 0;
      default: return 1;
    endcase
  endfunction
  // True when a count lies within a tolerance of its expectation.
  function automatic logic near(input int a, input int b, input int t);
    return (a >= b - t) && (a <= b + t);
  endfunction
  // Prints the verdict and ends the run.
  task automatic report_and_stop;
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    @(posedge sys_clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 20) begin
      n_fail++;
      report_and_stop();
    end
    r = rdat;
    req <= '0;
    @(posedge sys_clk_i);
  endtask
  // Resets the selector with a given configuration word.
  task automatic boot(input logic [2:0] s, input logic [1:0] m, input logic [1:0] sw, input logic of);
    cfg <= {5'h00, s, sw, of, 3'h0, m};
    stop <= 4'h0;
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  // Counts ticks over a window of 400 cycles.
  task automatic measure;
    pc = 0;
    icn = 0;
    st = '{0, 0, 0, 0};
    meas <= 1'b1;
    repeat (400) @(posedge sys_clk_i);
    meas <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // Main sequence: every source code, divider, switching, fail-safe and an unmapped read.
  initial begin
    void'($urandom(61482));
    for (int i = 0; i < 11; i++) begin
      w = 2'($urandom());
      o = 1'($urandom());
      boot(cs[i], cm[i], w, o);
      wb(1'b0, cks_pkg::REG_STAT, 32'h0, q);
      `CHK("stat_src", cs[i], q[2:0])
      `CHK("stat_swen", ~w[1], q[4])
      `CHK("stat_mon", w == 2'h0, q[5])
      wb(1'b0, cks_pkg::REG_CFG, 32'h0, q);
      `CHK("cfg", {w, o, 3'h0, cm[i]}, q[7:0])
      `CHK("primary_osc_en", cs[i][2:1] == 2'h1, pen)
      `CHK("pin_oe", o && (cm[i] == 2'h0 || cm[i] == 2'h3), poe)
      measure();
      k = xk(cs[i]);
      f = (cs[i] == 3'h1 || cs[i] == 3'h3) ? 4 : 1;
      `CHK("proc_ticks", 1'b1, near(pc, st[k] * f, f + 1))
      `CHK("instr_ticks", 1'b1, near(icn, pc / 2, 1))
      if (poe === 1'b1) `CHK("pin", ic, pin)
    end
    boot(3'h7, 2'h3, 2'h3, 1'b0);
    wb(1'b1, cks_pkg::REG_DIV, 32'h2, q);
    measure();
    `CHK("div_ticks", 1'b1, near(pc, st[1] / 4, 2))
    boot(3'h0, 2'h3, 2'h1, 1'b0);
    wb(1'b1, cks_pkg::REG_CTRL, 32'h15, q);
    for (int n = 0; n < 20; n++) begin
      wb(1'b0, cks_pkg::REG_STAT, 32'h0, q);
      if (q[7] === 1'b0) break;
    end
    `CHK("switch_src", 3'h5, q[2:0])
    measure();
    `CHK("lp_ticks", 1'b1, near(pc, st[0], 1))
    boot(3'h0, 2'h3, 2'h3, 1'b0);
    wb(1'b1, cks_pkg::REG_CTRL, 32'h15, q);
    repeat (40) @(posedge sys_clk_i);
    wb(1'b0, cks_pkg::REG_STAT, 32'h0, q);
    `CHK("locked_src", 3'h0, q[2:0])
    boot(3'h2, 2'h1, 2'h0, 1'b0);
    stop <= 4'h8;
    repeat (70) @(posedge sys_clk_i);
    wb(1'b0, cks_pkg::REG_STAT, 32'h0, q);
    `CHK("fail_src", 3'h0, q[2:0])
    `CHK("fail_flag", 1'b1, q[6])
    wb(1'b1, cks_pkg::REG_STAT, 32'h40, q);
    wb(1'b0, cks_pkg::REG_STAT, 32'h0, q);
    `CHK("fail_clear", 1'b0, q[6])
    boot(3'h2, 2'h1, 2'h2, 1'b0);
    stop <= 4'h8;
    repeat (70) @(posedge sys_clk_i);
    wb(1'b0, cks_pkg::REG_STAT, 32'h0, q);
    `CHK("nomon_src", 3'h2, q[2:0])
    wb(1'b0, 8'h10, 32'h0, q);
    `CHK("unmapped", 32'h00000000, q)
    ce <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 o = ic;
    repeat (10) @(posedge sys_clk_i);
    #1 `CHK("freeze", o, ic)
    @(posedge sys_clk_i);
    ce <= 1'b1;
    @(posedge sys_clk_i);
    report_and_stop();
  end
endmodule
`default_nettype wire
